//--- core/lom_pkg.sv
// constants, mode table and field layouts for the lane octet to sample mapper
// assumes a single clock domain running at the quad-byte processing rate
`default_nettype none

package lom_pkg;

    // lane and datapath geometry
    localparam int LANES      = 8;   // receive channels
    localparam int OCTETS     = 4;   // octets per lane per clock
    localparam int SER_BITS   = 40;  // serial bits per lane per clock
    localparam int LANE_W     = 32;  // parallel word per lane per clock
    localparam int GRP_W      = 96;  // longest octet group, three clocks
    localparam int SLOTS      = 64;  // widest sample group (mode 12)
    localparam int SMP_W      = 16;  // output sample width
    localparam int MODE_W     = 5;
    localparam int FIFO_DEPTH = 4;
    localparam int CLK_NS     = 10;  // processing clock period

    // per-mode mapping parameters, log2 fields keep all divisions as shifts
    typedef struct packed {
        logic       ok;    // mode supported
        logic [3:0] l;     // lanes
        logic [3:0] m;     // converters
        logic [3:0] f;     // octets per frame per lane
        logic [1:0] cyc;   // clocks per octet group
        logic [1:0] ls;    // log2 samples per converter per frame
        logic [1:0] lg;    // log2 frames per group
        logic [1:0] lspl;  // log2 samples per lane per frame
        logic       nib12; // 12-bit nibble packing
    } lom_mode_s;

    // mode number to layout, unsupported modes report ok low
    function automatic lom_mode_s lom_mode_decode(input logic [MODE_W-1:0] md);
        lom_mode_s d;
        d = '0;
        case (md)
            5'h00: d = '{1'b1, 4'h1, 4'h2, 4'h4, 2'h1, 2'h0, 2'h0, 2'h1, 1'b0};
            5'h01: d = '{1'b1, 4'h2, 4'h4, 4'h4, 2'h1, 2'h0, 2'h0, 2'h1, 1'b0};
            5'h02: d = '{1'b1, 4'h3, 4'h6, 4'h4, 2'h1, 2'h0, 2'h0, 2'h1, 1'b0};
            5'h03: d = '{1'b1, 4'h2, 4'h2, 4'h2, 2'h1, 2'h0, 2'h1, 2'h0, 1'b0};
            5'h04: d = '{1'b1, 4'h4, 4'h4, 4'h2, 2'h1, 2'h0, 2'h1, 2'h0, 1'b0};
            5'h05: d = '{1'b1, 4'h1, 4'h2, 4'h3, 2'h3, 2'h0, 2'h2, 2'h1, 1'b1};
            5'h06: d = '{1'b1, 4'h2, 4'h4, 4'h3, 2'h3, 2'h0, 2'h2, 2'h1, 1'b1};
            5'h07: d = '{1'b1, 4'h1, 4'h4, 4'h8, 2'h2, 2'h0, 2'h0, 2'h2, 1'b0};
            5'h09: d = '{1'b1, 4'h4, 4'h2, 4'h2, 2'h1, 2'h1, 2'h1, 2'h0, 1'b0};
            5'h0b: d = '{1'b1, 4'h8, 4'h2, 4'h2, 2'h1, 2'h2, 2'h1, 2'h0, 1'b0};
            5'h0c: d = '{1'b1, 4'h8, 4'h2, 4'h3, 2'h3, 2'h3, 2'h2, 2'h1, 1'b1};
            5'h13: d = '{1'b1, 4'h4, 4'h1, 4'h2, 2'h1, 2'h2, 2'h1, 2'h0, 1'b0};
            5'h15: d = '{1'b1, 4'h8, 4'h1, 4'h2, 2'h1, 2'h3, 2'h1, 2'h0, 1'b0};
            5'h16: d = '{1'b1, 4'h4, 4'h2, 4'h3, 2'h3, 2'h2, 2'h2, 2'h1, 1'b1};
            default: d = '0;
        endcase
        return d;
    endfunction

endpackage

`default_nettype wire

//--- core/lom_fifo.sv
// small first-in first-out buffer with a registered output stage
// assumes DEPTH is a power of two and at least two
`timescale 1ns/1ps
`default_nettype none

module lom_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    // write side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // read side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic [WIDTH-1:0]            dout;
        logic                        ov;
    } lom_fifo_s;

    lom_fifo_s r;
    lom_fifo_s next_r;
    logic      push;
    logic      load;

    // full counts only the memory, the output stage is extra slack
    assign in_ready_o  = r.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = r.ov;
    assign out_data_o  = r.dout;
    assign push        = in_valid_i && in_ready_o;
    assign load        = (!r.ov || out_ready_i) && r.cnt != '0;

    // pointer, count and output stage update
    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wp] = in_data_i;
            next_r.wp        = r.wp + AW'(1);
        end
        if (load) begin
            next_r.dout = r.mem[r.rp];
            next_r.rp   = r.rp + AW'(1);
            next_r.ov   = 1'b1;
        end else if (out_ready_i) begin
            next_r.ov = 1'b0;
        end
        next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(load);
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule

`default_nettype wire

//--- core/lom_mapper.sv
// lane octet to sample mapper: gathers octet groups per lane, routes them
// into per-converter samples and queues each group in a four-word fifo
// assumes deframed octets arrive on the processing clock, octet 0 in [31:24]
//
// Overview of operation
// - mode 3, lane n carries converter n, upper byte first, frame 1 holds sample 1.
// - mode 4, lane n carries converter n, upper byte octet 0, lower octet 1.
// - mode 9, lanes 0-1 converter 0 samples 0-1 then 2-3; lanes 2-3 converter 1.
// - mode 11, lanes 0-3 converter 0 samples 0-3 then 4-7; lanes 4-7 converter 1.
// - mode 19, lane k carries sample k then k+4 of converter 0.
// - mode 21, lane k carries sample k then k+8, upper byte first.
// - mode 5, three octets hold converter 0 then converter 1 as nibbles.
// - mode 6, lane 0 packs converters 0 and 1, lane 1 converters 2 and 3.
// - mode 22, lane 0 samples 0-1, lane 1 samples 2-3; lanes 2-3 converter 1.
// - mode 12, lane k packs samples 2k and 2k+1; lanes 4-7 converter 1.
// - mode 0, octets carry converter 0 then 1, upper byte first.
// - mode 1, lane 0 converters 0 and 1, lane 1 converters 2 and 3.
// - mode 2, lane k carries converters 2k and 2k+1, upper byte first.
// - mode 7, eight octets carry converters 0 to 3 in turn.
// - eight identical receive channels, each captured independently.
// - each channel delivers its 1:40 demultiplexed word to the logic.
// - logic runs at lane rate over 40, four bytes per clock.
`timescale 1ns/1ps
`default_nettype none

module lom_mapper #(
    parameter int FIFO_DEPTH = lom_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                                            ref_clk_i,
    input  wire logic                                            sys_rst_i,
    // mode selection
    input  wire logic [lom_pkg::MODE_W-1:0]                      mode_i,
    output logic                                                 mode_err_o,
    // octets from the receive channels
    input  wire logic                                            lane_valid_i,
    output logic                                                 lane_ready_o,
    input  wire logic [lom_pkg::LANES-1:0][lom_pkg::LANE_W-1:0]  lane_data_i,
    // reassembled samples
    output logic                                                 smp_valid_o,
    input  wire logic                                            smp_ready_i,
    output logic      [lom_pkg::SLOTS-1:0][lom_pkg::SMP_W-1:0]   smp_data_o,
    output logic      [lom_pkg::MODE_W-1:0]                      smp_mode_o
);

    localparam int FW = lom_pkg::MODE_W + lom_pkg::SLOTS * lom_pkg::SMP_W;

    typedef struct packed {
        logic [lom_pkg::LANES-1:0][lom_pkg::GRP_W-1:0] grp;   // octet group per lane
        logic [1:0]                                    cnt;   // clocks gathered
        logic [lom_pkg::MODE_W-1:0]                    gmode; // mode of this group
        logic                                          full;  // group ready to queue
        logic                                          err;   // unsupported mode seen
    } lom_st_s;

    lom_st_s                                r;
    lom_st_s                                next_r;
    lom_pkg::lom_mode_s                     d_in;
    lom_pkg::lom_mode_s                     d_grp;
    logic [lom_pkg::SLOTS-1:0][lom_pkg::SMP_W-1:0] slot;
    logic                                   fifo_rdy;
    logic                                   accept;
    logic                                   push;
    int                                     base;

    // one output slot: converter-major, then frame, then sample in frame
    function automatic logic [lom_pkg::SMP_W-1:0] map_slot(
        input lom_pkg::lom_mode_s                            d,
        input logic [lom_pkg::LANES-1:0][lom_pkg::GRP_W-1:0] g,
        input int                                            s
    );
        int         sg;
        int         conv;
        int         rem;
        int         fr;
        int         smp;
        int         q;
        int         ln;
        int         k;
        int         n0;
        logic [111:0] st;
        logic [lom_pkg::SMP_W-1:0] v;
        sg   = int'(d.ls) + int'(d.lg);
        conv = s >> sg;
        rem  = s & ((1 << sg) - 1);
        fr   = rem >> d.ls;
        smp  = rem & ((1 << d.ls) - 1);
        q    = (conv << d.ls) + smp;           // index within the frame
        ln   = q >> d.lspl;
        k    = q & ((1 << d.lspl) - 1);
        n0   = fr * 2 * int'(d.f) + k * (d.nib12 ? 3 : 4); // first nibble
        v    = '0;
        st   = '0;
        if (d.ok && conv < int'(d.m)) begin
            st = {g[ln[2:0]], 16'h0000};        // pad so a late sample stays in range
            v  = st[111 - 4 * n0 -: 16];
            if (d.nib12) begin
                v = {4'h0, v[15:4]};
            end
        end
        return v;
    endfunction

    assign d_grp        = lom_pkg::lom_mode_decode(r.gmode);
    assign lane_ready_o = !r.full || fifo_rdy;   // back-pressure from the fifo
    assign accept       = lane_valid_i && lane_ready_o;
    assign push         = r.full && fifo_rdy;
    assign mode_err_o   = r.err;

    // sample routing for every slot of the held group
    for (genvar s = 0; s < lom_pkg::SLOTS; s++) begin : g_slot
        assign slot[s] = map_slot(d_grp, r.grp, s);
    end

    // gather octets; the mode is taken at the first clock of each group
    always_comb begin
        d_in   = lom_pkg::lom_mode_decode(r.cnt == 2'h0 ? mode_i : r.gmode);
        base   = 0;
        next_r = r;
        if (push) begin
            next_r.full = 1'b0;
        end
        if (accept) begin
            if (!d_in.ok) begin
                next_r.err = 1'b1;
            end else begin
                if (r.cnt == 2'h0) begin
                    next_r.gmode = mode_i;
                    next_r.err   = 1'b0;
                    next_r.grp   = '0;
                end
                // four octets per clock per lane, oldest at the top
                base = lom_pkg::GRP_W - 1 - lom_pkg::LANE_W * int'(r.cnt);
                for (int l = 0; l < lom_pkg::LANES; l++) begin
                    if (l < int'(d_in.l)) begin
                        next_r.grp[l][base -: lom_pkg::LANE_W] = lane_data_i[l];
                    end
                end
                if (r.cnt + 2'h1 == d_in.cyc) begin
                    next_r.cnt  = 2'h0;
                    next_r.full = 1'b1;
                end else begin
                    next_r.cnt = r.cnt + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // whole groups queue here so a slow consumer stalls the lanes
    lom_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (r.full),
        .in_ready_o  (fifo_rdy),
        .in_data_i   ({r.gmode, slot}),
        .out_valid_o (smp_valid_o),
        .out_ready_i (smp_ready_i),
        .out_data_o  ({smp_mode_o, smp_data_o})
    );

    // checks on routing and completion of the group being queued
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_m3;
        (push && r.gmode == 5'h03) |-> slot[2] == r.grp[1][95:80];
    endproperty
    a_m3: assert property (p_m3)
        else $error("mode 3 converter 1 misrouted");

    property p_m4;
        (push && r.gmode == 5'h04) |-> slot[5] == r.grp[2][79:64];
    endproperty
    a_m4: assert property (p_m4)
        else $error("mode 4 converter 2 sample 1 misrouted");

    property p_m9;
        (push && r.gmode == 5'h09) |-> slot[3] == r.grp[1][79:64];
    endproperty
    a_m9: assert property (p_m9)
        else $error("mode 9 sample 3 misrouted");

    property p_m11;
        (push && r.gmode == 5'h0b) |-> slot[13] == r.grp[5][79:64];
    endproperty
    a_m11: assert property (p_m11)
        else $error("mode 11 converter 1 sample 5 misrouted");

    property p_m19;
        (push && r.gmode == 5'h13) |-> slot[6] == r.grp[2][79:64];
    endproperty
    a_m19: assert property (p_m19)
        else $error("mode 19 sample 6 misrouted");

    property p_m21;
        (push && r.gmode == 5'h15) |-> slot[8] == r.grp[0][79:64];
    endproperty
    a_m21: assert property (p_m21)
        else $error("mode 21 sample 8 misrouted");

    property p_m5;
        (push && r.gmode == 5'h05) |-> slot[4] == {4'h0, r.grp[0][83:72]};
    endproperty
    a_m5: assert property (p_m5)
        else $error("mode 5 converter 1 nibbles misplaced");

    property p_m22;
        (push && r.gmode == 5'h16) |-> slot[18] == {4'h0, r.grp[3][95:84]};
    endproperty
    a_m22: assert property (p_m22)
        else $error("mode 22 converter 1 sample 2 misrouted");

    property p_m12;
        (push && r.gmode == 5'h0c)
            |-> slot[9] == {4'h0, r.grp[0][59:48]} && slot[63][15:12] == 4'h0;
    endproperty
    a_m12: assert property (p_m12)
        else $error("mode 12 nibble join wrong");

    property p_m0;
        (push && r.gmode == 5'h00) |-> slot[1] == r.grp[0][79:64];
    endproperty
    a_m0: assert property (p_m0)
        else $error("mode 0 converter 1 misrouted");

    property p_m7;
        (push && r.gmode == 5'h07) |-> slot[3] == r.grp[0][47:32];
    endproperty
    a_m7: assert property (p_m7)
        else $error("mode 7 converter 3 misrouted");

    property p_m1;
        (push && r.gmode == 5'h01) |-> slot[2] == r.grp[1][95:80];
    endproperty
    a_m1: assert property (p_m1)
        else $error("mode 1 converter 2 misrouted");

    property p_m2;
        (push && r.gmode == 5'h02) |-> slot[5] == r.grp[2][79:64];
    endproperty
    a_m2: assert property (p_m2)
        else $error("mode 2 converter 5 misrouted");

    property p_m6;
        (push && r.gmode == 5'h06) |-> slot[12] == {4'h0, r.grp[1][83:72]};
    endproperty
    a_m6: assert property (p_m6)
        else $error("mode 6 converter 3 misrouted");

    property p_m12b;
        (push && r.gmode == 5'h0c) |-> slot[45] == {4'h0, r.grp[6][59:48]};
    endproperty
    a_m12b: assert property (p_m12b)
        else $error("mode 12 converter 1 lane 6 misrouted");

    property p_cyc2;
        (accept && r.cnt == 2'h0 && mode_i == 5'h07 && !r.full)
            ##1 accept |=> r.full && r.cnt == 2'h0;
    endproperty
    a_cyc2: assert property (p_cyc2)
        else $error("8-octet group not complete after two clocks");

    // a held group must survive a full fifo untouched
    property p_hold;
        (r.full && !fifo_rdy) |=> r.full && $stable(r.grp);
    endproperty
    a_hold: assert property (p_hold)
        else $error("held group changed under back-pressure");

    property p_errclr;
        (accept && r.cnt == 2'h0 && d_in.ok) |=> !mode_err_o;
    endproperty
    a_errclr: assert property (p_errclr)
        else $error("mode error not cleared by good group");

    property p_cyc3;
        (accept && r.cnt == 2'h0 && mode_i == 5'h16 && !r.full)
            ##1 (accept [*2]) |=> r.full && r.cnt == 2'h0;
    endproperty
    a_cyc3: assert property (p_cyc3)
        else $error("12-bit group not complete after three clocks");

    property p_err;
        (accept && r.cnt == 2'h0 && !d_in.ok) |=> mode_err_o && $stable(r.full && !push);
    endproperty
    a_err: assert property (p_err)
        else $error("unsupported mode not flagged");

    c_m12: cover property (push && r.gmode == 5'h0c);
    c_stall: cover property (r.full && !fifo_rdy);
    c_err: cover property (mode_err_o);
    c_m22: cover property (push && r.gmode == 5'h16);
    c_b2b: cover property (accept && push);

endmodule

`default_nettype wire

//--- verif/lom_lane_src.sv
// transmitter stand-in: offers deframed lane words over valid and ready
// assumes the bench steps it one word at a time, 1 ns after a clock edge
`timescale 1ns/1ps
`default_nettype none

module lom_lane_src (
    // clock
    input  wire logic                                           ref_clk_i,
    // lane words towards the mapper
    output logic                                                lane_valid_o,
    input  wire logic                                           lane_ready_i,
    output logic [lom_pkg::LANES-1:0][lom_pkg::LANE_W-1:0]      lane_data_o
);
    // quiet start, valid low from time zero
    initial begin
        lane_valid_o = 1'b0;
        lane_data_o  = '0;
    end

    // each lane carries its own word; held until the taking edge
    task automatic send_word(input logic [lom_pkg::LANES-1:0][lom_pkg::LANE_W-1:0] w);
        lane_valid_o = 1'b1;
        lane_data_o  = w;
        do @(posedge ref_clk_i); while (lane_ready_i !== 1'b1);
        #1;
    endtask

    // released lines flip so a stale word never passes for a good one
    task automatic idle();
        lane_valid_o = 1'b0;
        lane_data_o  = ~lane_data_o;
        @(posedge ref_clk_i);
        #1;
    endtask
endmodule

`default_nettype wire

//--- verif/lom_mapper_tb.sv
// self-checking bench for the lane octet to sample mapper
// assumes the transmitter stand-in lom_lane_src drives the lane side
`timescale 1ns/1ps
`default_nettype none

module lom_mapper_tb;
    typedef struct {
        logic [1023:0] d;
        logic [4:0]    m;
    } lom_exp_s;

    // mode, lanes, converters, octets per frame, samples per converter per frame
    localparam int TBL [14][5] = '{
        '{0, 1, 2, 4, 1},
        '{1, 2, 4, 4, 1},
        '{2, 3, 6, 4, 1},
        '{3, 2, 2, 2, 1},
        '{4, 4, 4, 2, 1},
        '{5, 1, 2, 3, 1},
        '{6, 2, 4, 3, 1},
        '{7, 1, 4, 8, 1},
        '{9, 4, 2, 2, 2},
        '{11, 8, 2, 2, 4},
        '{12, 8, 2, 3, 8},
        '{19, 4, 1, 2, 4},
        '{21, 8, 1, 2, 8},
        '{22, 4, 2, 3, 4}
    };

    logic                                           ref_clk_i = 1'b0;
    logic                                           sys_rst_i = 1'b1;
    logic [lom_pkg::MODE_W-1:0]                     mode_i    = '0;
    logic                                           smp_ready_i = 1'b1;
    logic                                           lane_valid_i;
    logic [lom_pkg::LANES-1:0][lom_pkg::LANE_W-1:0] lane_data_i;
    logic                                           mode_err_o;
    logic                                           lane_ready_o;
    logic                                           smp_valid_o;
    logic [lom_pkg::SLOTS-1:0][lom_pkg::SMP_W-1:0]  smp_data_o;
    logic [lom_pkg::MODE_W-1:0]                     smp_mode_o;
    lom_exp_s                                       exp_q [$];
    int                                             failures = 0;
    int                                             n_checks = 0;
    int                                             bp_mode  = 1;
    logic                                           saw_full = 1'b0;

    lom_mapper u_lom_mapper (
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .mode_i       (mode_i),
        .mode_err_o   (mode_err_o),
        .lane_valid_i (lane_valid_i),
        .lane_ready_o (lane_ready_o),
        .lane_data_i  (lane_data_i),
        .smp_valid_o  (smp_valid_o),
        .smp_ready_i  (smp_ready_i),
        .smp_data_o   (smp_data_o),
        .smp_mode_o   (smp_mode_o)
    );

    lom_lane_src u_lom_lane_src (
        .ref_clk_i    (ref_clk_i),
        .lane_valid_o (lane_valid_i),
        .lane_ready_i (lane_ready_o),
        .lane_data_o  (lane_data_i)
    );

    // processing clock, 10 ns period
    always #5 ref_clk_i = ~ref_clk_i;

    // consumer: always ready, random stalls, or fully stalled
    always @(posedge ref_clk_i) begin
        #1;
        smp_ready_i = (bp_mode == 0) ? 1'b1 : (bp_mode == 2) ? 1'b0 : 1'($urandom % 2);
    end

    // notes that the mapper pushed back at least once
    always @(posedge ref_clk_i) begin
        if (!sys_rst_i && lane_valid_i && !lane_ready_o) saw_full <= 1'b1;
    end

    task automatic check(input logic [1023:0] got, input logic [1023:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // output watcher: oldest note against each accepted sample group
    always @(posedge ref_clk_i) begin
        if (!sys_rst_i && smp_valid_o === 1'b1 && smp_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("wrong value at %0t ns: unexpected sample group", $time);
            end else begin
                check(smp_data_o, exp_q[0].d);
                check(1024'(smp_mode_o), 1024'(exp_q[0].m));
                void'(exp_q.pop_front());
            end
        end
    end

    // builds one octet group for table row i, notes the samples, sends it
    task automatic run_group(input int i);
        logic [lom_pkg::LANES-1:0][lom_pkg::GRP_W-1:0]  grp;
        logic [lom_pkg::LANES-1:0][lom_pkg::LANE_W-1:0] wd;
        lom_exp_s                                       e;
        logic [15:0]                                    v;
        int nl, nm, nf, ns, g, spl, lpc, k, cv, sm, nc;
        nl = TBL[i][1];
        nm = TBL[i][2];
        nf = TBL[i][3];
        ns = TBL[i][4];
        g = (nf == 2) ? 2 : (nf == 3) ? 4 : 1;
        spl = (nf == 3) ? 2 : nf / 2;
        lpc = (ns == 1) ? 1 : nl / nm;
        nc = (nf == 3) ? 3 : (nf == 8) ? 2 : 1;
        e.d = '0;
        e.m = 5'(TBL[i][0]);
        // lanes beyond the mode's count carry junk that must be ignored
        for (int ln = 0; ln < 8; ln++) begin
            grp[ln] = {$urandom, $urandom, $urandom};
            k = 0;
            for (int fr = 0; fr < g; fr++)
                for (int j = 0; j < spl && ln < nl; j++) begin
                    v = 16'($urandom);
                    cv = (ns == 1) ? ln * spl + j : ln / lpc;
                    sm = (ns == 1) ? 0 : (ln % lpc) * spl + j;
                    if (nf == 3) begin
                        v[15:12] = 4'h0;
                        grp[ln][95 - k * 12 -: 12] = v[11:0];
                    end else begin
                        grp[ln][95 - k * 16 -: 16] = v;
                    end
                    e.d[(cv * ns * g + fr * ns + sm) * 16 +: 16] = v;
                    k++;
                end
        end
        mode_i = e.m;
        exp_q.push_back(e);
        for (int c = 0; c < nc; c++) begin
            for (int ln = 0; ln < 8; ln++) wd[ln] = grp[ln][95 - 32 * c -: 32];
            u_lom_lane_src.send_word(wd);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #(30000 * lom_pkg::CLK_NS);
        failures++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(78));
        repeat (10) @(posedge ref_clk_i);
        #1;
        check(1024'({smp_valid_o, lane_ready_o, mode_err_o, smp_mode_o}), 1024'(8'h40));
        check(smp_data_o, '0);
        repeat (10) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        // every mode twice, back to back or with a gap, random stalls
        for (int i = 0; i < 14; i++) begin
            run_group(i);
            run_group(i);
            if ($urandom % 2) u_lom_lane_src.idle();
        end
        // unsupported mode flags, a good group clears it
        u_lom_lane_src.idle();
        mode_i = 5'h08;
        u_lom_lane_src.send_word('1);
        u_lom_lane_src.idle();
        check(1024'(mode_err_o), 1024'(1'b1));
        run_group(4);
        u_lom_lane_src.idle();
        check(1024'(mode_err_o), 1024'(1'b0));
        // fill until refused, then drain with random stalls
        bp_mode = 2;
        fork
            for (int n = 0; n < 9; n++) run_group(4);
            begin
                repeat (40) @(posedge ref_clk_i);
                bp_mode = 1;
            end
        join
        check(1024'(saw_full), 1024'(1'b1));
        for (int n = 0; n < 20; n++) run_group(int'($urandom % 14));
        u_lom_lane_src.idle();
        bp_mode = 0;
        for (int t = 0; t < 200 && (exp_q.size() != 0 || smp_valid_o !== 1'b0); t++)
            @(posedge ref_clk_i);
        #1;
        check(1024'(exp_q.size()), '0);
        check(1024'(smp_valid_o), '0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
